// file: src/rss_pkg.sv
package rss_pkg;

    // Clock and delay figures
    localparam int CLK_PERIOD_NS      = 10;
    localparam int BIAS_SETTLE_NS     = 5000;
    localparam int BIAS_SETTLE_CYC    = (BIAS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_UP_DELAY_MS  = 64;
    localparam int POWER_UP_DELAY_CYC = POWER_UP_DELAY_MS * (1000000 / CLK_PERIOD_NS);

    // Register byte addresses on the bus
    localparam logic [3:0] RCR_ADDR  = 4'h0;
    localparam logic [3:0] STAT_ADDR = 4'h4;

    // Reset control register layout and value after power-on
    localparam int RCR_TRAP    = 15;
    localparam int RCR_ILLEGAL = 14;
    localparam int RCR_SOFTWARE_BROWNOUT_ENABLE  = 13;
    localparam int RCR_DPSLP   = 10;
    localparam int RCR_PIN     = 7;
    localparam int RCR_SW      = 6;
    localparam int RCR_WATCHDOG_TIMEOUT_FLAG    = 4;
    localparam int RCR_SLEEP   = 3;
    localparam int RCR_IDLE    = 2;
    localparam int RCR_BOR     = 1;
    localparam int RCR_POR     = 0;
    localparam logic [15:0] RCR_RESET = 16'h0003;
    localparam logic [15:0] RCR_IMPL  = 16'hE4DF;

    // Power configuration word fields
    localparam int CFG_MODE_LO  = 0;
    localparam int CFG_THR_LO   = 5;
    localparam int CFG_POWER_UP_TIMER_EN  = 7;

    // Brown-out modes and special values
    localparam logic [1:0] BOR_OFF    = 2'h0;
    localparam logic [1:0] BOR_SW     = 2'h1;
    localparam logic [1:0] BOR_AWAKE  = 2'h2;
    localparam logic [1:0] BOR_ALWAYS = 2'h3;
    localparam logic [1:0] THR_LOW_POWER = 2'h0;
    localparam logic [7:0] ILLEGAL_OPCODE = 8'h3F;
    localparam logic [3:0] STACK_PTR_IDX  = 4'hF;

    // Start-up sequencer states, Gray coded along the path
    typedef enum logic [1:0] {
        SEQ_BIAS  = 2'b00,
        SEQ_POWER_UP_TIMER  = 2'b01,
        SEQ_RUN   = 2'b11,
        SEQ_BROWN = 2'b10
    } rss_seq_t;

    // Events from the processor core
    typedef struct packed {
        logic        sw_reset;
        logic        hard_trap;
        logic        soft_trap;
        logic        instr_valid;
        logic [23:0] instr_word;
        logic        wreg_wr;
        logic [3:0]  wreg_wr_idx;
        logic        ptr_use;
        logic [3:0]  ptr_use_idx;
    } rss_cpu_evt_t;

endpackage

// file: src/rss_hold_timer.sv
`timescale 1ns/1ns
`default_nettype none

module rss_hold_timer
    import rss_pkg::*;
#(
    parameter int COUNT = 500,
    parameter int CW    = $clog2(COUNT + 1)
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic arst_n,
    // Control
    input  wire logic run,
    // Status
    output logic      expired
);

    logic [CW-1:0] cnt;

    // Counts while run is held, restarts whenever run drops
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= '0;
        end else if (!run) begin
            cnt <= '0;
        end else if (cnt != CW'(COUNT - 1)) begin
            cnt <= cnt + 1'b1;
        end
    end

    // Expired after COUNT consecutive edges with run high
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            expired <= 1'b0;
        end else begin
            expired <= run && (cnt == CW'(COUNT - 1));
        end
    end

endmodule

`default_nettype wire

// file: src/rss_reset_seq.sv
// Functional notes
// - Power-on restarts timers, reloads configured clock
// - Wait bias settle delay after power-on
// - Add power-up delay when timer enabled
// - Power-on sets brown-out and power-on flags
// - Release clock only after all delays
// - Filtered low pin holds master reset
// - Pin reset keeps clock, sets pin flag
// - Reset instruction pulses reset one cycle
// - Watchdog resets; in sleep/idle only wakes
// - Threshold bits 6:5, mode bits 1:0
// - Mode: off, software, awake-only, always
// - Brown-out holds reset until supply recovers
// - Supply drop in power-up delay restarts it
// - Brown-out and power-up timer independent
// - Software enable acts only in mode 01
// - Threshold always from configuration word
// - Brown-out or power-on sets brown-out flag
// - Deep sleep exit sets both power flags
// - Awake-only mode disables brown-out in sleep
// - Threshold 00 selects low-power detector
// - Simultaneous traps reset, set trap flag
// - Illegal opcode resets, sets illegal flag
// - Upper byte 3Fh is illegal opcode
// - Uninitialized working register pointer resets
// - Software flag writes never cause reset
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module rss_reset_seq
    import rss_pkg::*;
#(
    parameter int POWER_UP_TIMER_CYC     = POWER_UP_DELAY_CYC,
    parameter int PIN_MIN_NS   = 100,
    parameter int PIN_MIN_CYC  = (PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    // Pin and supply monitors
    input  wire logic         external_reset_pin_n,
    input  wire logic         por_pulse,
    input  wire logic         supply_below_thresh,
    input  wire logic         lp_supply_below,
    input  wire logic [7:0]   power_config_word,
    // Power modes and watchdog
    input  wire logic         in_sleep,
    input  wire logic         in_idle,
    input  wire logic         deep_sleep_exit,
    input  wire logic         wdt_timeout,
    // Processor events
    input  wire rss_cpu_evt_t cpu_evt,
    // Wishbone slave
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [3:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic              wb_ack_o,
    output logic [31:0]       wb_dat_o,
    // Reset and clock control
    output logic              master_reset_line,
    output logic              clk_release,
    output logic              osc_reload,
    output logic              cpu_wake,
    // Brown-out detector control
    output logic              bor_detector_enable,
    output logic              lp_detector_select,
    output logic [1:0]        brownout_threshold_select
);

    // Mode decode shared by enable logic and status read
    function automatic logic bor_on(input logic [1:0] mode, input logic sben, input logic sleep);
        case (mode)
            BOR_OFF:    bor_on = 1'b0;
            BOR_SW:     bor_on = sben;
            BOR_AWAKE:  bor_on = !sleep;
            BOR_ALWAYS: bor_on = 1'b1;
            default:    bor_on = 1'b0;
        endcase
    endfunction

    function automatic logic is_illegal(input logic [23:0] word);
        is_illegal = (word[23:16] == ILLEGAL_OPCODE);
    endfunction

    rss_seq_t    seq_state;
    rss_seq_t    next_state;
    logic [15:0] rcr;
    logic [14:0] wreg_init;
    logic        bias_done;
    logic        power_up_timer_done;
    logic        pin_active;
    logic [1:0]  bor_mode;
    logic [1:0]  bor_thr;
    logic        power_up_timer_en;
    logic        bor_en;
    logic        trip;
    logic        por_evt;
    logic        trap_conflict;
    logic        illegal_op;
    logic        uninit_use;
    logic        wdt_reset;
    logic        bus_req;
    logic        rcr_wr;
    logic [15:0] wmask;
    logic [15:0] hw_set;
    logic [15:0] rcr_view;

    // Configuration fields
    assign bor_mode = power_config_word[CFG_MODE_LO +: 2];
    assign bor_thr  = power_config_word[CFG_THR_LO +: 2];
    assign power_up_timer_en  = power_config_word[CFG_POWER_UP_TIMER_EN];

    // Effective brown-out enable and trip source
    assign bor_en  = bor_on(bor_mode, rcr[RCR_SOFTWARE_BROWNOUT_ENABLE], in_sleep);
    assign trip    = bor_en && ((bor_thr == THR_LOW_POWER) ? lp_supply_below : supply_below_thresh);
    assign por_evt = por_pulse || deep_sleep_exit;

    // Core-side reset sources
    assign trap_conflict = cpu_evt.hard_trap && cpu_evt.soft_trap;
    assign illegal_op    = cpu_evt.instr_valid && is_illegal(cpu_evt.instr_word);
    assign uninit_use    = cpu_evt.ptr_use && (cpu_evt.ptr_use_idx != STACK_PTR_IDX)
                           && !wreg_init[cpu_evt.ptr_use_idx[3:0]];
    assign wdt_reset     = wdt_timeout && !in_sleep && !in_idle;

    // Bias settle, power-up and pin filter timers
    rss_hold_timer #(.COUNT(BIAS_SETTLE_CYC)) u_bias (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .run     (seq_state == SEQ_BIAS && !por_evt),
        .expired (bias_done)
    );

    rss_hold_timer #(.COUNT(POWER_UP_TIMER_CYC)) u_power_up_timer (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .run     (seq_state == SEQ_POWER_UP_TIMER),
        .expired (power_up_timer_done)
    );

    rss_hold_timer #(.COUNT(PIN_MIN_CYC)) u_pin (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .run     (!external_reset_pin_n),
        .expired (pin_active)
    );

    // Start-up sequencer next state
    always_comb begin
        next_state = seq_state;
        if (por_evt) begin
            next_state = SEQ_BIAS;
        end else begin
            case (seq_state)
                SEQ_BIAS: begin
                    if (bias_done) begin
                        next_state = power_up_timer_en ? SEQ_POWER_UP_TIMER : SEQ_RUN;
                    end
                end
                SEQ_POWER_UP_TIMER: begin
                    if (trip) begin
                        next_state = SEQ_BROWN;
                    end else if (power_up_timer_done) begin
                        next_state = SEQ_RUN;
                    end
                end
                SEQ_RUN: begin
                    if (trip) begin
                        next_state = SEQ_BROWN;
                    end
                end
                SEQ_BROWN: begin
                    if (!trip) begin
                        next_state = power_up_timer_en ? SEQ_POWER_UP_TIMER : SEQ_RUN;
                    end
                end
                default: next_state = SEQ_BIAS;
            endcase
        end
    end

    // Sequencer state
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            seq_state <= SEQ_BIAS;
        end else begin
            seq_state <= next_state;
        end
    end

    // Master reset, clock release and wake outputs
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            master_reset_line <= 1'b1;
            clk_release       <= 1'b0;
            osc_reload        <= 1'b1;
            cpu_wake          <= 1'b0;
        end else begin
            master_reset_line <= (next_state != SEQ_RUN) || pin_active || wdt_reset
                                 || cpu_evt.sw_reset || trap_conflict || illegal_op
                                 || uninit_use;
            clk_release       <= (next_state == SEQ_RUN);
            osc_reload        <= por_evt || (next_state == SEQ_BROWN);
            cpu_wake          <= wdt_timeout && (in_sleep || in_idle);
        end
    end

    // Brown-out detector controls
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bor_detector_enable       <= 1'b0;
            lp_detector_select        <= 1'b0;
            brownout_threshold_select <= 2'h0;
        end else begin
            bor_detector_enable       <= bor_en;
            lp_detector_select        <= bor_en && (bor_thr == THR_LOW_POWER);
            brownout_threshold_select <= bor_thr;
        end
    end

    // Working register initialization tracking
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wreg_init <= '0;
        end else if (master_reset_line) begin
            wreg_init <= '0;
        end else if (cpu_evt.wreg_wr && cpu_evt.wreg_wr_idx != STACK_PTR_IDX) begin
            wreg_init[cpu_evt.wreg_wr_idx[3:0]] <= 1'b1;
        end
    end

    // Hardware flag sets
    always_comb begin
        hw_set              = '0;
        hw_set[RCR_TRAP]    = trap_conflict;
        hw_set[RCR_ILLEGAL] = illegal_op || uninit_use;
        hw_set[RCR_DPSLP]   = deep_sleep_exit;
        hw_set[RCR_PIN]     = pin_active;
        hw_set[RCR_SW]      = cpu_evt.sw_reset;
        hw_set[RCR_WATCHDOG_TIMEOUT_FLAG]    = wdt_timeout;
        hw_set[RCR_SLEEP]   = in_sleep;
        hw_set[RCR_IDLE]    = in_idle;
        hw_set[RCR_BOR]     = por_evt || (next_state == SEQ_BROWN && seq_state != SEQ_BROWN);
        hw_set[RCR_POR]     = por_evt;
    end

    // Bus strobes and byte-lane mask for the flag register
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign rcr_wr  = bus_req && wb_we_i && wb_ack_o && (wb_adr_i == RCR_ADDR);
    assign wmask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & RCR_IMPL;

    // Reset control register: reload RCR_RESET (0003h) on power-on pulse, software write, hardware set wins
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rcr <= RCR_RESET;
        end else if (por_pulse) begin
            rcr <= RCR_RESET;
        end else if (rcr_wr) begin
            rcr <= ((rcr & ~wmask) | (wb_dat_i[15:0] & wmask)) | hw_set;
        end else begin
            rcr <= rcr | hw_set;
        end
    end

    // Software enable reads as zero outside software mode
    always_comb begin
        rcr_view             = rcr;
        rcr_view[RCR_SOFTWARE_BROWNOUT_ENABLE] = rcr[RCR_SOFTWARE_BROWNOUT_ENABLE] && (bor_mode == BOR_SW);
    end

    // Wishbone acknowledge: one wait cycle, dropped the cycle after
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
        end
    end

    // Read data captured with the acknowledge; unmapped reads return zero
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req && !wb_ack_o) begin
            case (wb_adr_i)
                RCR_ADDR:  wb_dat_o <= {16'h0000, rcr_view};
                STAT_ADDR: wb_dat_o <= {22'h00_0000, seq_state, bor_en, power_up_timer_en,
                                        bor_thr, bor_mode, trip, pin_active};
                default:   wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    chk_sw_pulse: assert property (cpu_evt.sw_reset |=> master_reset_line && rcr[RCR_SW])
        else $error("reset instruction did not pulse master reset");
    chk_bias_exit: assert property (seq_state == SEQ_BIAS && next_state != SEQ_BIAS && !por_evt |-> bias_done)
        else $error("left bias settle before delay expired");
    chk_power_up_timer_skip: assert property (seq_state == SEQ_BIAS && bias_done && !power_up_timer_en && !por_evt
                                    |=> seq_state == SEQ_RUN)
        else $error("power-up delay inserted while disabled");
    chk_clk_release: assert property (clk_release |-> seq_state == SEQ_RUN && !$past(por_evt))
        else $error("clock released before start-up delays ended");
    chk_por_flags: assert property (por_pulse |=> rcr[1:0] == 2'b11 && master_reset_line ##1 seq_state == SEQ_BIAS)
        else $error("power-on flags or reset missing");
    chk_pin_reset: assert property (pin_active |=> master_reset_line && rcr[RCR_PIN])
        else $error("filtered pin low did not reset");
    chk_wdt_wake: assert property (wdt_timeout && (in_sleep || in_idle) |=> cpu_wake && rcr[RCR_WATCHDOG_TIMEOUT_FLAG])
        else $error("watchdog in low power did not wake");
    chk_trap_reset: assert property (trap_conflict |=> master_reset_line && rcr[RCR_TRAP])
        else $error("trap conflict did not reset");
    chk_illegal_op: assert property (illegal_op |=> master_reset_line && rcr[RCR_ILLEGAL])
        else $error("illegal opcode did not reset");
    chk_brown_hold: assert property (trip && !por_evt |=> seq_state == SEQ_BROWN && master_reset_line)
        else $error("brown-out did not hold reset");

    cov_power_up_timer_brown: cover property (seq_state == SEQ_POWER_UP_TIMER ##1 seq_state == SEQ_BROWN);
    cov_power_up_timer_run: cover property (seq_state == SEQ_POWER_UP_TIMER ##1 seq_state == SEQ_RUN);
    cov_pin_reset: cover property ($rose(pin_active));
    cov_uninit: cover property (uninit_use);

endmodule

`default_nettype wire

// file: test/rss_supply_model.sv
`timescale 1ns/1ns
`default_nettype none

// Reset pin with its pull-up, plus the main and low-power supply comparators
module rss_supply_model (
    // Clock
    input  wire logic clk_sys,
    // Requests from the bench
    input  wire logic pin_hold,
    input  wire logic drop_main,
    input  wire logic drop_lp,
    input  wire logic power_up,
    // Lines into the block
    output logic      external_reset_pin_n,
    output logic      supply_below_thresh,
    output logic      lp_supply_below,
    output logic      por_pulse
);
    logic power_up_q = 1'b0;

    // Pull-up holds the pin high unless something pulls it low
    assign external_reset_pin_n = ~pin_hold;
    assign supply_below_thresh  = drop_main;
    assign lp_supply_below      = drop_lp;

    // The power-on circuit fires once on each rise of the supply
    always_ff @(posedge clk_sys) begin
        power_up_q <= power_up;
    end
    assign por_pulse = power_up & ~power_up_q;
endmodule

`default_nettype wire

// file: test/test_rss_reset_seq.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end

module test_rss_reset_seq
    import rss_pkg::*;
;
    localparam int POWER_UP_TIMER = 20;

    logic         clk_sys   = 1'b0;
    logic         arst_n    = 1'b0;
    logic         pin_hold  = 1'b0;
    logic         drop_main = 1'b0;
    logic         drop_lp   = 1'b0;
    logic         power_up  = 1'b0;
    logic [7:0]   cfg       = 8'h00;
    logic         in_sleep  = 1'b0;
    logic         in_idle   = 1'b0;
    logic         dse       = 1'b0;
    logic         wdt       = 1'b0;
    rss_cpu_evt_t ev        = '0;
    logic         cyc       = 1'b0;
    logic         stb       = 1'b0;
    logic         we        = 1'b0;
    logic [3:0]   adr       = 4'h0;
    logic [3:0]   sel       = 4'h0;
    logic [31:0]  dat       = 32'h0000_0000;
    logic [31:0]  rd;
    wire logic    pin_n, below, lp_below, por, ack, mrl, clk_rel, osc, wake, bor_en, lp_sel;
    wire logic [1:0]  thr;
    wire logic [31:0] dato;
    int           error_cnt = 0, cmp_count = 0, cycles = 0, n = 0;
    int           rst_cnt = 0, osc_cnt = 0, wake_cnt = 0, r0, o0, w0;

    always #5 clk_sys = ~clk_sys;

    rss_supply_model supply (.clk_sys(clk_sys), .pin_hold(pin_hold), .drop_main(drop_main), .drop_lp(drop_lp),
        .power_up(power_up), .external_reset_pin_n(pin_n), .supply_below_thresh(below),
        .lp_supply_below(lp_below), .por_pulse(por));

    rss_reset_seq #(.POWER_UP_TIMER_CYC(POWER_UP_TIMER), .PIN_MIN_NS(30)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .external_reset_pin_n(pin_n), .por_pulse(por), .supply_below_thresh(below), .lp_supply_below(lp_below),
        .power_config_word(cfg), .in_sleep(in_sleep), .in_idle(in_idle), .deep_sleep_exit(dse),
        .wdt_timeout(wdt), .cpu_evt(ev), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(dato), .master_reset_line(mrl),
        .clk_release(clk_rel), .osc_reload(osc), .cpu_wake(wake), .bor_detector_enable(bor_en),
        .lp_detector_select(lp_sel), .brownout_threshold_select(thr));

    // Count the cycles each watched output is high, and cut a hang short
    always @(posedge clk_sys) begin
        rst_cnt  <= rst_cnt + int'(mrl);
        osc_cnt  <= osc_cnt + int'(osc);
        wake_cnt <= wake_cnt + int'(wake);
        cycles   <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("Compares %0d, errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One classic bus cycle; read data is taken at the ack edge
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v);
        int t;
        t = 0;
        @(posedge clk_sys);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hF, v};
        @(posedge clk_sys);
        while (ack !== 1'b1 && t < 50) begin
            @(posedge clk_sys);
            t++;
        end
        if (t >= 50)
            error_cnt++;
        rd = dato;
        {cyc, stb, we} <= 3'b000;
    endtask

    task automatic wait_rel();
        n = 0;
        while (clk_rel !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            n++;
        end
    endtask

    // Clear the flags and note the counters before a case
    task automatic start();
        wb(1'b1, RCR_ADDR, 32'h0);
        r0 = rst_cnt;
        o0 = osc_cnt;
        w0 = wake_cnt;
    endtask

    task automatic fin(input logic rs, input logic [15:0] fl, input logic [15:0] m);
        repeat (4) @(posedge clk_sys);
        `CHK(rst_cnt != r0, rs)
        `CHK(osc_cnt, o0)
        `CHK(mrl, 1'b0)
        wb(1'b0, RCR_ADDR, 32'h0);
        `CHK(rd[15:0] & m, fl)
    endtask

    function automatic rss_cpu_evt_t mk(logic s, logic h, logic f, logic iv, logic [23:0] iw,
                                         logic ww, logic [3:0] wi, logic pu, logic [3:0] pi);
        return '{s, h, f, iv, iw, ww, wi, pu, pi};
    endfunction

    task automatic ev_case(input rss_cpu_evt_t e, input logic [15:0] fl, input logic rs);
        start();
        ev <= e;
        @(posedge clk_sys);
        ev <= '0;
        fin(rs, fl, 16'hFFFF);
    endtask

    task automatic wdt_case(input logic s, input logic i, input logic rs, input logic [15:0] fl, input logic [15:0] m);
        start();
        in_sleep <= s;
        in_idle  <= i;
        @(posedge clk_sys);
        wdt <= 1'b1;
        @(posedge clk_sys);
        wdt <= 1'b0;
        repeat (3) @(posedge clk_sys);
        `CHK(wake_cnt != w0, ~rs)
        in_sleep <= 1'b0;
        in_idle  <= 1'b0;
        fin(rs, fl, m);
    endtask

    task automatic pin_case(input int k, input logic rs, input logic [15:0] fl);
        start();
        pin_hold <= 1'b1;
        repeat (k) @(posedge clk_sys);
        `CHK(mrl, rs)
        pin_hold <= 1'b0;
        fin(rs, fl, 16'hFFFF);
    endtask

    // Brown-out entry, optional second drop while the power-up delay runs
    task automatic bor_run(input logic [7:0] c, input logic g);
        cfg <= c;
        start();
        drop_main <= 1'b1;
        repeat (10) @(posedge clk_sys);
        `CHK(mrl, 1'b1)
        `CHK(clk_rel, 1'b0)
        drop_main <= 1'b0;
        if (g) begin
            repeat (10) @(posedge clk_sys);
            `CHK(mrl, 1'b1)
            drop_main <= 1'b1;
            repeat (2) @(posedge clk_sys);
            drop_main <= 1'b0;
        end
        wait_rel();
        wb(1'b0, RCR_ADDR, 32'h0);
        `CHK(rd[15:0], 16'h0002)
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        wb(1'b0, RCR_ADDR, 32'h0);
        `CHK(rd, 32'h0000_0003)
        `CHK(mrl, 1'b1)
        wait_rel();
        `CHK(n >= 490 && n <= 505, 1'b1)
        `CHK(mrl, 1'b0)
        wb(1'b0, STAT_ADDR, 32'h0);
        `CHK(rd, {22'h00_0000, SEQ_RUN, 8'h00})
        ev_case(mk(1, 0, 0, 0, 0, 0, 0, 0, 0), 16'h0040, 1'b1);
        ev_case(mk(0, 1, 1, 0, 0, 0, 0, 0, 0), 16'h8000, 1'b1);
        ev_case(mk(0, 1, 0, 0, 0, 0, 0, 0, 0), 16'h0000, 1'b0);
        ev_case(mk(0, 0, 0, 1, 24'h3F_1234, 0, 0, 0, 0), 16'h4000, 1'b1);
        ev_case(mk(0, 0, 0, 1, 24'h3E_FFFF, 0, 0, 0, 0), 16'h0000, 1'b0);
        ev_case(mk(0, 0, 0, 0, 0, 0, 0, 1, 4'h5), 16'h4000, 1'b1);
        ev_case(mk(0, 0, 0, 0, 0, 1, 4'h5, 0, 0), 16'h0000, 1'b0);
        ev_case(mk(0, 0, 0, 0, 0, 0, 0, 1, 4'h5), 16'h0000, 1'b0);
        ev_case(mk(0, 0, 0, 0, 0, 0, 0, 1, 4'hF), 16'h0000, 1'b0);
        wdt_case(1'b0, 1'b0, 1'b1, 16'h0010, 16'hFFFF);
        wdt_case(1'b1, 1'b0, 1'b0, 16'h0008, 16'hFFEF);
        wdt_case(1'b0, 1'b1, 1'b0, 16'h0004, 16'hFFEF);
        pin_case(2, 1'b0, 16'h0000);
        pin_case(8, 1'b1, 16'h0080);
        start();
        wb(1'b1, RCR_ADDR, 32'h0000_00D0);
        fin(1'b0, 16'h00D0, 16'hFFFF);
        wb(1'b1, 4'hC, 32'hFFFF_FFFF);
        wb(1'b0, 4'hC, 32'h0);
        `CHK(rd, 32'h0000_0000)
        // Brown-out modes and the software enable
        cfg <= 8'h21;
        repeat (3) @(posedge clk_sys);
        `CHK(bor_en, 1'b0)
        wb(1'b1, RCR_ADDR, 32'h0000_2000);
        repeat (3) @(posedge clk_sys);
        `CHK(bor_en, 1'b1)
        `CHK(thr, 2'b01)
        wb(1'b0, RCR_ADDR, 32'h0);
        `CHK(rd[13], 1'b1)
        cfg <= 8'h23;
        wb(1'b0, RCR_ADDR, 32'h0);
        `CHK(rd[13], 1'b0)
        `CHK(bor_en, 1'b1)
        cfg <= 8'h40;
        repeat (3) @(posedge clk_sys);
        `CHK(bor_en, 1'b0)
        `CHK(thr, 2'b10)
        cfg <= 8'h22;
        in_sleep <= 1'b1;
        repeat (3) @(posedge clk_sys);
        `CHK(bor_en, 1'b0)
        in_sleep <= 1'b0;
        repeat (3) @(posedge clk_sys);
        `CHK(bor_en, 1'b1)
        cfg <= 8'h03;
        start();
        `CHK(lp_sel, 1'b1)
        drop_lp <= 1'b1;
        repeat (5) @(posedge clk_sys);
        `CHK(mrl, 1'b1)
        drop_lp <= 1'b0;
        wait_rel();
        bor_run(8'h23, 1'b0);
        `CHK(n <= 4, 1'b1)
        bor_run(8'hA3, 1'b0);
        `CHK(n >= 19 && n <= 24, 1'b1)
        bor_run(8'hA3, 1'b1);
        `CHK(n >= 19 && n <= 24, 1'b1)
        // Power-on pulse and deep-sleep exit restart the bias settle
        start();
        power_up <= 1'b1;
        @(posedge clk_sys);
        power_up <= 1'b0;
        repeat (3) @(posedge clk_sys);
        `CHK(mrl, 1'b1)
        `CHK(osc_cnt != o0, 1'b1)
        wb(1'b0, RCR_ADDR, 32'h0);
        `CHK(rd[15:0], 16'h0003)
        wait_rel();
        `CHK(n >= 510 && n <= 525, 1'b1)
        start();
        dse <= 1'b1;
        @(posedge clk_sys);
        dse <= 1'b0;
        repeat (3) @(posedge clk_sys);
        wb(1'b0, RCR_ADDR, 32'h0);
        `CHK(rd[15:0], 16'h0403)
        wait_rel();
        wrap_up();
    end
endmodule

`default_nettype wire
